// *** common/wdh_regs.svh ***
// register offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDH_REGS_SVH
`define WDH_REGS_SVH

`define WDH_ADR_SETTING 8'h00
`define WDH_ADR_STATUS 8'h04
`define WDH_ADR_TIMER_CTRL 8'h08

`define WDH_SETTING_RESET 8'h07
`define WDH_TIMER_CTRL_RESET 8'h08
`define WDH_TIMER_CTRL_UNUSED_BIT 5
`define WDH_SEL_HI 2
`define WDH_SEL_LO 0
`define WDH_TIMEOUT_BIT 5
`define WDH_POWERDOWN_BIT 4
`define WDH_PIN_IDLE 11'h7fc

`define WDH_CLK_MHZ 25
`define WDH_SST_PERIODS 1024
`define WDH_SST_CYCLES (`WDH_SST_PERIODS)
`define WDH_OPTLOAD_CYCLES 16
`define WDH_INSTR_DIV 4
`define WDH_BASE_DIV 16'h0100
`define WDH_CNT_W 16
`define WDH_DELAY_W 11

`define WDH_SRC_WDT_OSC 2'h0
`define WDH_SRC_RTC 2'h1
`define WDH_SRC_INSTR 2'h2

`endif

// *** common/wdh_pkg.sv ***
// types shared by the watchdog, halt and reset-cause block
package wdh_pkg;

  typedef enum logic [1:0] {
    WDH_ST_OPTLOAD,
    WDH_ST_STARTUP,
    WDH_ST_RUN,
    WDH_ST_HALT
  } wdh_state_type;

  typedef enum logic [1:0] {
    WDH_WK_NONE,
    WDH_WK_NEXT,
    WDH_WK_IRQ,
    WDH_WK_RESET
  } wdh_wake_type;

endpackage

// *** rtl/wdh_top.sv ***
// watchdog timer with halt, wake-up, start-up delay and reset-cause flags
//
// Contract
// - count clock: osc, rtc or sysclk/4 option
// - disabled watchdog ignores every related action
// - fixed divide-by-256 base stage first
// - setting bits 2..0 select 1:1 to 1:128
// - setting bits 7..3 are plain user flags
// - instruction clock stops counting while halted
// - overflow in run: chip reset, set timeout
// - overflow in halt: warm reset PC, SP
// - pin low, clear, halt clear the count
// - single clear, or first plus second clear
// - halt stops system clock, holds state
// - halt sets powerdown, clears timeout, restarts count
// - powerdown cleared by power-up or clear
// - wake: pin reset, interrupt, overflow, port fall
// - port wake resumes next; interrupt wake responds if serviceable, else next
// - request pending before halt cannot wake
// - 1024-cycle start-up delay after resets, wakes
// - timeout, powerdown flags record reset cause
// - option load delay except warm reset
// - chip reset clears PC, counters, ports input
// - setting 07h, timer control 08h except warm
// - status bit 5 timeout, bit 4 powerdown
`include "wdh_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module wdh_top #(
  parameter bit WDT_ENABLE = 1'b1,
  parameter logic [1:0] CLK_SRC = `WDH_SRC_WDT_OSC,
  parameter bit DUAL_CLEAR = 1'b0,
  parameter logic [7:0] PA_WAKE_EN = 8'hff
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic external_reset_pin_n_in,
  input wire logic wdt_osc_in,
  input wire logic rtc_clk_in,
  input wire logic [7:0] porta_in,
  input wire logic dog_clear_single_in,
  input wire logic dog_clear_first_in,
  input wire logic dog_clear_second_in,
  input wire logic halt_in,
  input wire logic [1:0] irq_req_in,
  input wire logic irq_serviceable_in,
  output logic chip_reset_out,
  output logic warm_reset_out,
  output logic option_load_out,
  output logic startup_busy_out,
  output logic halted_out,
  output logic core_run_out,
  output logic wake_next_out,
  output logic wake_irq_out,
  output logic timeout_flag_out,
  output logic powerdown_flag_out,
  output logic [7:0] timer_control_out
);

  // pin synchronisers: osc, rtc, reset pin, port A
  localparam int SYNC_W = 11;
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync3_q;
  logic [SYNC_W-1:0] stable_q;
  logic [SYNC_W-1:0] stable_d;
  logic [SYNC_W-1:0] rise;
  logic [SYNC_W-1:0] fall;

  assign pin_raw = {porta_in, external_reset_pin_n_in, rtc_clk_in, wdt_osc_in};

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      // chain starts at the idle pin levels, else a false pin reset follows power-up
      sync1_q <= `WDH_PIN_IDLE;
      sync2_q <= `WDH_PIN_IDLE;
      sync3_q <= `WDH_PIN_IDLE;
    end
    else
    begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a level counts once the second and third stages agree
  always_comb
  begin
    for (int i = 0; i < SYNC_W; i++)
    begin
      stable_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : stable_q[i];
    end
  end

  // reset pin and port bits idle high so a power-up does not look like an edge
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      stable_q <= `WDH_PIN_IDLE;
    end
    else
    begin
      stable_q <= stable_d;
    end
  end

  assign rise = stable_d & ~stable_q;
  assign fall = ~stable_d & stable_q;

  logic ext_rst_active;
  logic [7:0] porta_fall;
  assign ext_rst_active = ~stable_q[2];
  assign porta_fall = fall[10:3];

  // state and registers
  wdh_pkg::wdh_state_type state_q;
  wdh_pkg::wdh_wake_type wake_q;
  logic [`WDH_DELAY_W-1:0] delay_q;
  logic [`WDH_CNT_W-1:0] cnt_q;
  logic [1:0] instr_div_q;
  logic [7:0] setting_q;
  logic [7:0] timer_ctrl_q;
  logic timeout_q;
  logic powerdown_q;
  logic first_seen_q;
  logic second_seen_q;
  logic [1:0] irq_masked_q;
  logic warm_q;

  // core commands and watchdog events
  logic run;
  logic halting;
  logic dog_clear;
  logic tick;
  logic overflow;
  logic cnt_clear;
  logic full_reset;
  logic irq_wake;
  logic port_wake;
  logic [`WDH_CNT_W-1:0] terminal;

  assign run = (state_q == wdh_pkg::WDH_ST_RUN);
  assign halting = run && halt_in;

  always_comb
  begin
    dog_clear = 1'b0;
    if (WDT_ENABLE && run)
    begin
      if (DUAL_CLEAR)
      begin
        dog_clear = (first_seen_q || dog_clear_first_in) &&
                    (second_seen_q || dog_clear_second_in);
      end
      else
      begin
        dog_clear = dog_clear_single_in;
      end
    end
  end

  // both halves of a dual clear must be seen before the count is cleared
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      first_seen_q <= 1'b0;
      second_seen_q <= 1'b0;
    end
    else if (dog_clear || halting || !run)
    begin
      first_seen_q <= 1'b0;
      second_seen_q <= 1'b0;
    end
    else
    begin
      first_seen_q <= first_seen_q || (WDT_ENABLE && dog_clear_first_in);
      second_seen_q <= second_seen_q || (WDT_ENABLE && dog_clear_second_in);
    end
  end

  // instruction clock is the system clock over four
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      instr_div_q <= '0;
    end
    else
    begin
      instr_div_q <= instr_div_q + 2'h1;
    end
  end

  always_comb
  begin
    unique case (CLK_SRC)
      `WDH_SRC_WDT_OSC: tick = rise[0];
      `WDH_SRC_RTC: tick = rise[1];
      // system oscillator is off in halt, so this source stalls there
      default: tick = (state_q != wdh_pkg::WDH_ST_HALT) &&
                      (instr_div_q == 2'(`WDH_INSTR_DIV - 1));
    endcase
  end

  assign terminal = (`WDH_BASE_DIV << setting_q[`WDH_SEL_HI:`WDH_SEL_LO]) - 16'h0001;
  assign overflow = WDT_ENABLE && tick && (cnt_q == terminal) &&
                    (run || state_q == wdh_pkg::WDH_ST_HALT);
  assign cnt_clear = ext_rst_active || dog_clear || halting;

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cnt_q <= '0;
    end
    else if (cnt_clear || overflow || !(run || state_q == wdh_pkg::WDH_ST_HALT))
    begin
      cnt_q <= '0;
    end
    else if (WDT_ENABLE && tick)
    begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // wake sources while halted
  assign irq_wake = |(irq_req_in & ~irq_masked_q);
  assign port_wake = |(porta_fall & PA_WAKE_EN);
  assign full_reset = ext_rst_active || (run && overflow);

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      irq_masked_q <= '0;
    end
    else if (halting)
    begin
      irq_masked_q <= irq_req_in;
    end
  end

  // sequencer: option load, start-up delay, run, halt
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= wdh_pkg::WDH_ST_OPTLOAD;
      delay_q <= '0;
      wake_q <= wdh_pkg::WDH_WK_RESET;
    end
    else if (full_reset)
    begin
      state_q <= wdh_pkg::WDH_ST_OPTLOAD;
      delay_q <= '0;
      wake_q <= wdh_pkg::WDH_WK_RESET;
    end
    else
    begin
      unique case (state_q)
        wdh_pkg::WDH_ST_OPTLOAD:
        begin
          if (delay_q == `WDH_DELAY_W'(`WDH_OPTLOAD_CYCLES - 1))
          begin
            state_q <= wdh_pkg::WDH_ST_STARTUP;
            delay_q <= '0;
          end
          else
          begin
            delay_q <= delay_q + 1'b1;
          end
        end
        wdh_pkg::WDH_ST_STARTUP:
        begin
          if (delay_q == `WDH_DELAY_W'(`WDH_SST_CYCLES - 1))
          begin
            state_q <= wdh_pkg::WDH_ST_RUN;
            delay_q <= '0;
          end
          else
          begin
            delay_q <= delay_q + 1'b1;
          end
        end
        wdh_pkg::WDH_ST_RUN:
        begin
          wake_q <= wdh_pkg::WDH_WK_NONE;
          if (halting)
          begin
            state_q <= wdh_pkg::WDH_ST_HALT;
          end
        end
        wdh_pkg::WDH_ST_HALT:
        begin
          if (overflow)
          begin
            state_q <= wdh_pkg::WDH_ST_STARTUP;
            wake_q <= wdh_pkg::WDH_WK_NEXT;
          end
          else if (port_wake)
          begin
            state_q <= wdh_pkg::WDH_ST_STARTUP;
            wake_q <= wdh_pkg::WDH_WK_NEXT;
          end
          else if (irq_wake)
          begin
            state_q <= wdh_pkg::WDH_ST_STARTUP;
            wake_q <= irq_serviceable_in ? wdh_pkg::WDH_WK_IRQ : wdh_pkg::WDH_WK_NEXT;
          end
        end
      endcase
    end
  end

  // warm reset pulse: PC and SP only, nothing else reloads
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      warm_q <= 1'b0;
    end
    else
    begin
      warm_q <= (state_q == wdh_pkg::WDH_ST_HALT) && overflow && !ext_rst_active;
    end
  end

  // timeout and powerdown flags; a set wins over a clear in the same cycle
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      timeout_q <= 1'b0;
      powerdown_q <= 1'b0;
    end
    else
    begin
      if (overflow)
      begin
        timeout_q <= 1'b1;
      end
      else if (dog_clear || halting)
      begin
        timeout_q <= 1'b0;
      end
      if (halting)
      begin
        powerdown_q <= 1'b1;
      end
      else if (dog_clear)
      begin
        powerdown_q <= 1'b0;
      end
    end
  end

  // setting and timer control: reloaded by every reset but the warm one
  logic wb_hit;
  logic wr_byte0;
  assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
  // write lands on the edge at which the master sees ack
  assign wr_byte0 = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in && wb_sel_in[0];

  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      setting_q <= `WDH_SETTING_RESET;
      timer_ctrl_q <= `WDH_TIMER_CTRL_RESET;
    end
    else if (full_reset)
    begin
      setting_q <= `WDH_SETTING_RESET;
      timer_ctrl_q <= `WDH_TIMER_CTRL_RESET;
    end
    else if (wr_byte0 && wb_adr_in == `WDH_ADR_SETTING)
    begin
      setting_q <= wb_dat_in[7:0];
    end
    else if (wr_byte0 && wb_adr_in == `WDH_ADR_TIMER_CTRL)
    begin
      timer_ctrl_q <= wb_dat_in[7:0];
      timer_ctrl_q[`WDH_TIMER_CTRL_UNUSED_BIT] <= 1'b0;
    end
  end

  // wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end
    else
    begin
      wb_ack_out <= wb_hit;
      wb_dat_out <= '0;
      if (wb_hit && !wb_we_in)
      begin
        unique case (wb_adr_in)
          `WDH_ADR_SETTING: wb_dat_out[7:0] <= setting_q;
          `WDH_ADR_STATUS:
          begin
            wb_dat_out[`WDH_TIMEOUT_BIT] <= timeout_q;
            wb_dat_out[`WDH_POWERDOWN_BIT] <= powerdown_q;
          end
          `WDH_ADR_TIMER_CTRL: wb_dat_out[7:0] <= timer_ctrl_q;
          default: wb_dat_out <= '0;
        endcase
      end
    end
  end

  // outputs toward the core
  assign chip_reset_out = (state_q == wdh_pkg::WDH_ST_OPTLOAD) ||
                          (state_q == wdh_pkg::WDH_ST_STARTUP &&
                           wake_q == wdh_pkg::WDH_WK_RESET);
  assign option_load_out = (state_q == wdh_pkg::WDH_ST_OPTLOAD);
  assign startup_busy_out = (state_q == wdh_pkg::WDH_ST_STARTUP);
  assign halted_out = (state_q == wdh_pkg::WDH_ST_HALT);
  assign core_run_out = run;
  assign warm_reset_out = warm_q;
  assign wake_next_out = run && wake_q == wdh_pkg::WDH_WK_NEXT;
  assign wake_irq_out = run && wake_q == wdh_pkg::WDH_WK_IRQ;
  assign timeout_flag_out = timeout_q;
  assign powerdown_flag_out = powerdown_q;
  assign timer_control_out = timer_ctrl_q;

endmodule

`default_nettype wire

// *** rtl/wdh_tie.sv ***
// reserved
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** verification/wdh_core_model.sv ***
// processor core model issuing halt and clear instruction pulses
`timescale 1ns/1ps
`default_nettype none
module wdh_core_model (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic core_run_in,
  input wire logic [1:0] req_in,
  output logic halt_out,
  output logic clr_single_out,
  output logic clr_first_out,
  output logic clr_second_out
);
  // a held core issues nothing, so requests outside run are dropped here
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      halt_out <= 1'b0;
      clr_single_out <= 1'b0;
      clr_first_out <= 1'b0;
      clr_second_out <= 1'b0;
    end
    else
    begin
      halt_out <= core_run_in && req_in == 2'h1;
      clr_single_out <= core_run_in && req_in == 2'h2;
      clr_first_out <= core_run_in && req_in == 2'h3;
      clr_second_out <= core_run_in && clr_first_out;
    end
endmodule
`default_nettype wire

// *** verification/wdh_chk.sv ***
// concurrent checks on the watchdog block ports
`include "wdh_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module wdh_chk (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic halt_in,
  input wire logic dog_clear_single_in,
  input wire logic core_run_out,
  input wire logic halted_out,
  input wire logic chip_reset_out,
  input wire logic warm_reset_out,
  input wire logic option_load_out,
  input wire logic startup_busy_out,
  input wire logic timeout_flag_out,
  input wire logic powerdown_flag_out,
  input wire logic [7:0] timer_control_out
);
  logic [10:0] busy_cnt_q;
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
      busy_cnt_q <= 11'h000;
    else
      busy_cnt_q <= startup_busy_out ? busy_cnt_q + 11'h001 : 11'h000;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_halt_cmd;
    core_run_out && halt_in;
  endsequence
  sequence s_halted;
    halted_out && powerdown_flag_out && !timeout_flag_out;
  endsequence
  sequence s_sst_end;
    $fell(startup_busy_out);
  endsequence
  AST_HALT_ENTRY: assert property (s_halt_cmd |=> s_halted)
    else $error("halt entry flags wrong");
  AST_CLR_PD: assert property (core_run_out && dog_clear_single_in && !halt_in |=>
    !powerdown_flag_out) else $error("clear left powerdown set");
  AST_HALT_HOLD: assert property (halted_out |-> !core_run_out)
    else $error("core runs while halted");
  AST_RESET_RUN: assert property (chip_reset_out |-> !core_run_out && !halted_out)
    else $error("core active in chip reset");
  AST_SST_LEN: assert property (s_sst_end |-> busy_cnt_q == 11'h400)
    else $error("start-up delay length wrong");
  AST_SST_RUN: assert property (s_sst_end |-> core_run_out)
    else $error("no run after start-up");
  AST_WARM_KEEP: assert property (warm_reset_out |-> !chip_reset_out &&
    !option_load_out && $stable(timer_control_out)) else $error("warm reset too wide");
  AST_TO_CAUSE: assert property ($rose(timeout_flag_out) |->
    ##[0:2] (chip_reset_out || warm_reset_out)) else $error("timeout without reset");
  AST_WARM_SST: assert property (warm_reset_out |-> ##[0:2] startup_busy_out)
    else $error("no start-up after warm reset");
  AST_TCTL_LOAD: assert property ($fell(chip_reset_out) |->
    timer_control_out == `WDH_TIMER_CTRL_RESET) else $error("timer control not reloaded");
endmodule
bind wdh_top wdh_chk chk (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .halt_in(halt_in),
  .dog_clear_single_in(dog_clear_single_in), .core_run_out(core_run_out),
  .halted_out(halted_out), .chip_reset_out(chip_reset_out), .warm_reset_out(warm_reset_out),
  .option_load_out(option_load_out), .startup_busy_out(startup_busy_out),
  .timeout_flag_out(timeout_flag_out), .powerdown_flag_out(powerdown_flag_out),
  .timer_control_out(timer_control_out));
`default_nettype wire

// *** verification/wdh_tb_top.sv ***
// testbench for the watchdog, halt and reset-cause block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 3000) begin @(posedge clk); k++; end \
  if (k == 3000) fail_count++; end
module wdh_tb_top;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, pin_n = 1'b1, osc = 1'b0;
  logic [7:0] adr = 8'h00, pa = 8'hff;
  logic [31:0] wdat = 32'h0000_0000, q;
  logic [3:0] sel = 4'h0;
  logic [1:0] req = 2'h0;
  logic [1:0] irq = 2'h0;
  logic svc = 1'b0;
  wire logic [31:0] rdat;
  wire logic [7:0] tctl;
  wire logic ack, hlt, cs, c1, c2, crst, warm, run, wnext, to, pd, hw, wirq;
  int fail_count = 0, n_tests = 0, k;
  wdh_top dut (.mclk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel), .wb_dat_out(rdat),
    .wb_ack_out(ack), .external_reset_pin_n_in(pin_n), .wdt_osc_in(osc), .rtc_clk_in(1'b0),
    .porta_in(pa), .dog_clear_single_in(cs), .dog_clear_first_in(c1),
    .dog_clear_second_in(c2), .halt_in(hlt), .irq_req_in(irq), .irq_serviceable_in(svc),
    .chip_reset_out(crst), .warm_reset_out(warm), .option_load_out(), .startup_busy_out(),
    .halted_out(hw), .core_run_out(run), .wake_next_out(wnext), .wake_irq_out(wirq),
    .timeout_flag_out(to), .powerdown_flag_out(pd), .timer_control_out(tctl));
  wdh_core_model core (.mclk_in(clk), .sys_rst_in(rst), .core_run_in(run), .req_in(req),
    .halt_out(hlt), .clr_single_out(cs), .clr_first_out(c1), .clr_second_out(c2));
  always #20 clk = ~clk;
  // free-running dog oscillator, one tick every 4 cycles
  always
  begin
    repeat (2) @(posedge clk);
    osc <= ~osc;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h00_0000, d}; sel <= 4'h1;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (n == 50) fail_count++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input logic [1:0] c);
    req <= c;
    @(posedge clk);
    req <= 2'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `WAIT(run === 1'b1)
    bus(0, 8'h00, 8'h00); `CHK(q, 32'h0000_0007)
    `CHK(tctl, 8'h08)
    bus(0, 8'h04, 8'h00); `CHK(q, 32'h0000_0000)
    bus(0, 8'h0c, 8'h00); `CHK(q, 32'h0000_0000)
    cmd(2'h2);
    bus(1, 8'h00, 8'ha9); bus(0, 8'h00, 8'h00); `CHK(q, 32'h0000_00a9)
    $display("test reset values done");
    cmd(2'h1); `CHK(run, 1'b0)
    `CHK({to, pd}, 2'b01)
    pa <= 8'hfe;
    `WAIT(run === 1'b1)
    `CHK(wnext, 1'b1)
    `CHK({to, pd}, 2'b01)
    pa <= 8'hff;
    cmd(2'h2); `CHK(pd, 1'b0)
    $display("test port wake done");
    cmd(2'h1);
    `WAIT(warm === 1'b1)
    @(posedge clk); `CHK({to, pd}, 2'b11)
    `WAIT(run === 1'b1)
    `CHK(wnext, 1'b1)
    bus(0, 8'h00, 8'h00); `CHK(q, 32'h0000_00a9)
    $display("test warm reset done");
    cmd(2'h2);
    bus(1, 8'h00, 8'ha8);
    for (int i = 0; i < 4; i++)
    begin
      repeat (600) @(posedge clk);
      cmd(2'h2); `CHK(run, 1'b1)
    end
    `WAIT(crst === 1'b1)
    `CHK(k >= 1016 && k <= 1028, 1'b1)
    @(posedge clk); `CHK({to, pd}, 2'b10)
    `WAIT(run === 1'b1)
    bus(0, 8'h00, 8'h00); `CHK(q, 32'h0000_0007)
    $display("test run overflow done");
    pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    pin_n <= 1'b1;
    `WAIT(run === 1'b1)
    `CHK({to, pd}, 2'b10)
    cmd(2'h1);
    pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    pin_n <= 1'b1;
    `WAIT(run === 1'b1)
    `CHK({to, pd}, 2'b01)
    $display("test pin reset done");
    // a request already pending at halt entry must not wake
    irq <= 2'h2;
    svc <= 1'b1;
    cmd(2'h1);
    repeat (50) @(posedge clk);
    `CHK(hw, 1'b1)
    irq <= 2'h3;
    `WAIT(run === 1'b1)
    `CHK(wirq, 1'b1)
    irq <= 2'h0;
    svc <= 1'b0;
    cmd(2'h1);
    irq <= 2'h1;
    `WAIT(run === 1'b1)
    `CHK(wnext, 1'b1)
    irq <= 2'h0;
    $display("test interrupt wake done");
    results();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
